// [design/prom_pkg.sv]
// constants, pin bundle and state codes for the serial configuration readout
package prom_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned SYS_PERIOD_NS   = 100;
    localparam int unsigned CFG_HALF_NS     = 400;
    localparam int unsigned POR_TIME_NS     = 2000;
    localparam logic [7:0]  CFG_HALF_CYC    = 8'((CFG_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
    localparam logic [15:0] POR_CYC         = 16'((POR_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

    // ------------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------------
    localparam int unsigned ARRAY_ADDR_W    = 25;
    localparam int unsigned PAGE_SEL_W      = 2;

    // ------------------------------------------------------------------
    // register map (byte offsets) and fields
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  MEM_ADDR_OFS    = 8'h04;
    localparam logic [7:0]  MEM_DATA_OFS    = 8'h08;
    localparam logic [7:0]  STATUS_OFS      = 8'h0C;
    localparam logic [7:0]  BIT_POS_OFS     = 8'h10;
    localparam int unsigned CTRL_HOLD_BIT   = 0;
    localparam logic        CTRL_HOLD_RST   = 1'b0;
    localparam int unsigned ST_DONE_BIT     = 0;
    localparam int unsigned ST_STANDBY_BIT  = 1;
    localparam int unsigned ST_PROG_BIT     = 2;
    localparam int unsigned ST_READY_BIT    = 3;
    localparam int unsigned ST_SHIFT_BIT    = 4;

    typedef struct packed {
        logic                  serial_prog_enable;
        logic                  sel_n;
        logic                  oe;
        logic                  page_en;
        logic [PAGE_SEL_W-1:0] part;
    } pin_in_t;

    typedef enum logic [2:0] {
        RD_IDLE  = 3'b001,
        RD_SHIFT = 3'b010,
        RD_DONE  = 3'b100
    } rd_state_t;
endpackage

// [design/serial_config_prom_readout.sv]
// serial configuration memory readout with cascade, paging, standby and apb loading
//
// Contract
// - bit stream leaves on the data output
// - serial clock pin drives out during configuration
// - ready held low through power-on reset
// - last bit clocked: cascade low, data off
// - selected downstream memory enables data output
// - reset input low resets address counter
// - programming enable low selects programming mode
// - enable high and select high: standby
// - standby keeps data output floating
// - reset input low clears counter, floats data
// - only selected and enabled: count and drive
// - paging splits space into four partitions
// - cascade low at partition or device top
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module serial_config_prom_readout #(
    parameter int unsigned ADDR_W = prom_pkg::ARRAY_ADDR_W
) (
    input  wire logic       sys_clk_in,                 // system clock, 10 MHz
    input  wire logic       reset_n_in,                 // synchronous reset, active low
    input  wire logic       psel_in,                    // apb select
    input  wire logic       penable_in,                 // apb access phase
    input  wire logic       pwrite_in,                  // apb direction
    input  wire logic [7:0] paddr_in,                   // apb byte address
    input  wire logic [31:0] pwdata_in,                 // apb write data
    output logic      [31:0] prdata_out,                // apb read data
    output logic            pready_out,                 // apb ready
    output logic            pslverr_out,                // apb error on unmapped address
    input  wire logic       serial_prog_enable_in,      // pin: high for readout
    input  wire logic       device_select_n_in,         // pin: chip select, active low
    input  wire logic       reset_oe_in,                // pin: low resets, high enables
    input  wire logic       page_enable_in,             // pin: paging enable
    input  wire logic [1:0] partition_select_in,        // pin: partition choice
    output logic            data_out,                   // data pin drive value
    output logic            data_oe_out,                // data pin output enable
    input  wire logic       data_in,                    // data pin level, programming only
    output logic            serial_config_clock_out,    // clock pin drive value
    output logic            serial_config_clock_oe_out, // clock pin output enable
    input  wire logic       serial_config_clock_in,     // clock pin level, programming only
    output logic            cascade_out_n_out,          // cascade output, active low
    output logic            ready_out,                  // ready pin drive value, always low
    output logic            ready_oe_out,               // ready pin pull-down enable
    output logic            standby_out,                // low-power standby indication
    output logic            prog_mode_out               // programming mode indication
);
    import prom_pkg::*;

    localparam int unsigned WORD_W = ADDR_W - 5;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    pin_in_t pin_meta_r;
    pin_in_t pin_s_r;
    pin_in_t pin_raw;

    assign pin_raw = '{serial_prog_enable: serial_prog_enable_in, sel_n: device_select_n_in,
                       oe: reset_oe_in, page_en: page_enable_in, part: partition_select_in};

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            pin_meta_r <= '{serial_prog_enable: 1'b1, sel_n: 1'b1, oe: 1'b0, page_en: 1'b0, part: 2'h0};
            pin_s_r    <= '{serial_prog_enable: 1'b1, sel_n: 1'b1, oe: 1'b0, page_en: 1'b0, part: 2'h0};
        end
        else
        begin
            pin_meta_r <= pin_raw;
            pin_s_r    <= pin_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // power-on reset sequence
    // ------------------------------------------------------------------
    logic [15:0] por_cnt_r;
    logic        por_done_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            por_cnt_r  <= 16'h0000;
            por_done_r <= 1'b0;
        end
        else if (!por_done_r)
        begin
            por_cnt_r  <= por_cnt_r + 16'h0001;
            por_done_r <= (por_cnt_r == POR_CYC - 16'h0001);
        end
    end

    assign ready_out    = 1'b0;
    assign ready_oe_out = !por_done_r;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire readout_mode = pin_s_r.serial_prog_enable && por_done_r;
    wire selected     = readout_mode && !pin_s_r.sel_n && pin_s_r.oe;

    assign standby_out   = pin_s_r.serial_prog_enable && pin_s_r.sel_n;
    assign prog_mode_out = !pin_s_r.serial_prog_enable;

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    logic [31:0]       mem [0:(1 << WORD_W) - 1];
    logic              hold_r;
    logic [WORD_W-1:0] mem_addr_r;
    logic [31:0]       prdata_r;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == CTRL_OFS) || (a == MEM_ADDR_OFS) || (a == MEM_DATA_OFS)
               || (a == STATUS_OFS) || (a == BIT_POS_OFS);
    endfunction

    rd_state_t         st_r;
    rd_state_t         st_nxt;
    logic [ADDR_W-1:0] offset_r;

    wire apb_setup = psel_in && !penable_in;
    wire apb_wr    = psel_in && penable_in && pwrite_in && reg_hit(paddr_in);
    wire [31:0] status_word = {27'h0, st_r == RD_SHIFT, por_done_r, prog_mode_out,
                               standby_out, st_r == RD_DONE};
    wire [31:0] rd_mux =
        (paddr_in == CTRL_OFS)     ? {31'h0, hold_r} :
        (paddr_in == MEM_ADDR_OFS) ? 32'(mem_addr_r) :
        (paddr_in == MEM_DATA_OFS) ? mem[mem_addr_r] :
        (paddr_in == STATUS_OFS)   ? status_word :
        (paddr_in == BIT_POS_OFS)  ? 32'(offset_r) : 32'h0000_0000;

    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !reg_hit(paddr_in);
    assign prdata_out  = prdata_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            hold_r     <= CTRL_HOLD_RST;
            mem_addr_r <= '0;
            prdata_r   <= 32'h0000_0000;
        end
        else
        begin
            if (apb_setup)
                prdata_r <= rd_mux;
            if (apb_wr && paddr_in == CTRL_OFS)
                hold_r <= pwdata_in[CTRL_HOLD_BIT];
            if (apb_wr && paddr_in == MEM_ADDR_OFS)
                mem_addr_r <= pwdata_in[WORD_W-1:0];
            else if (apb_wr && paddr_in == MEM_DATA_OFS)
                mem_addr_r <= mem_addr_r + 1'b1;
        end
    end

    // no reset on the array: it models non-volatile contents
    always_ff @(posedge sys_clk_in)
    begin
        if (apb_wr && paddr_in == MEM_DATA_OFS)
            mem[mem_addr_r] <= pwdata_in;
    end

    // ------------------------------------------------------------------
    // serial clock generator
    // ------------------------------------------------------------------
    logic [7:0] div_r;
    logic       clk_r;

    wire run  = (st_r == RD_SHIFT) && selected && !hold_r;
    wire tick = run && (div_r == CFG_HALF_CYC - 8'h01);
    wire rise = tick && !clk_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in || !run)
        begin
            div_r <= 8'h00;
            clk_r <= 1'b0;
        end
        else
        begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            clk_r <= tick ? !clk_r : clk_r;
        end
    end

    assign serial_config_clock_out    = clk_r;
    assign serial_config_clock_oe_out = run;

    // ------------------------------------------------------------------
    // address counter, partitions and readout state
    // ------------------------------------------------------------------
    wire at_top = pin_s_r.page_en ? (&offset_r[ADDR_W-3:0]) : (&offset_r);
    wire [ADDR_W-1:0] bit_addr = pin_s_r.page_en
        ? {pin_s_r.part, offset_r[ADDR_W-3:0]} : offset_r;

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            RD_IDLE:  if (selected) st_nxt = RD_SHIFT;
            RD_SHIFT: if (!selected) st_nxt = RD_IDLE;
                      else if (rise && at_top) st_nxt = RD_DONE;
            RD_DONE:  st_nxt = RD_DONE;
            default:  st_nxt = RD_IDLE;
        endcase
        if (!pin_s_r.oe || !readout_mode)
            st_nxt = RD_IDLE;
    end

    logic data_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            st_r     <= RD_IDLE;
            offset_r <= '0;
            data_r   <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            data_r <= mem[bit_addr[ADDR_W-1:5]][bit_addr[4:0]];
            if (!pin_s_r.oe)
                offset_r <= '0;
            else if (run && rise && !at_top)
                offset_r <= offset_r + 1'b1;
        end
    end

    // data drives only while shifting; standby and programming float it
    assign data_out          = data_r;
    assign data_oe_out       = (st_r == RD_SHIFT) && selected;
    // cascade follows select after the top until reset input falls or programming enable goes low
    assign cascade_out_n_out = (st_r == RD_DONE) ? pin_s_r.sel_n : 1'b1;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_last_edge;
        rise && at_top && st_r == RD_SHIFT && selected;
    endsequence
    sequence s_done_quiet;
        !data_oe_out && st_r == RD_DONE;
    endsequence

    property p_last_bit;
        s_last_edge |=> s_done_quiet ##0 (cascade_out_n_out == pin_s_r.sel_n);
    endproperty
    a_last_bit: assert property (p_last_bit) else $error("cascade/data wrong after top");

    property p_reset_clears;
        !pin_s_r.oe |=> offset_r == '0 && !data_oe_out;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset input low ignored");

    property p_standby_float;
        standby_out |-> !data_oe_out && !serial_config_clock_oe_out;
    endproperty
    a_standby_float: assert property (p_standby_float) else $error("data driven in standby");

    property p_standby_flag;
        pin_s_r.serial_prog_enable && pin_s_r.sel_n |-> standby_out && cascade_out_n_out;
    endproperty
    a_standby_flag: assert property (p_standby_flag) else $error("standby not entered");

    property p_advance;
        rise && run && !at_top |=> offset_r == $past(offset_r) + 1'b1;
    endproperty
    a_advance: assert property (p_advance) else $error("counter did not advance");

    property p_no_count_deselected;
        pin_s_r.sel_n && pin_s_r.oe |=> $stable(offset_r);
    endproperty
    a_no_count_deselected: assert property (p_no_count_deselected) else $error("counted while deselected");

    property p_prog_mode;
        !pin_s_r.serial_prog_enable |-> prog_mode_out && !data_oe_out && !serial_config_clock_oe_out;
    endproperty
    a_prog_mode: assert property (p_prog_mode) else $error("readout active in programming mode");

    property p_ready_release;
        $rose(por_done_r) |-> !ready_oe_out ##1 !ready_oe_out;
    endproperty
    a_ready_release: assert property (p_ready_release) else $error("ready not released");

    // checked from the release edge on, since the disable covers the reset cycles themselves
    property p_ready_hold;
        $rose(reset_n_in) |-> ready_oe_out [*3];
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready released early");

    property p_clock_out;
        selected && st_r == RD_SHIFT && !hold_r |-> serial_config_clock_oe_out && data_oe_out;
    endproperty
    a_clock_out: assert property (p_clock_out) else $error("clock pin not driven");
endmodule

// [tb/fpga_cfg_sink.sv]
// behavioural fpga configuration input that captures one bit at each serial clock rise
`timescale 1ns/10ps
module fpga_cfg_sink #(
    parameter int unsigned NBITS = 256
) (
    input  wire logic        sys_clk_in,  // sampling clock
    input  wire logic        clear_in,    // restart capture at bit 0
    input  wire logic        cfg_clk_in,  // serial configuration clock wire level
    input  wire logic        cfg_data_in, // serial data wire level
    output logic [NBITS-1:0] bits_out,    // captured stream, first bit at index 0
    output logic [15:0]      count_out    // number of bits captured
);
    logic clk_prev_r;
    logic data_prev_r;

    // the wire is sampled by the system clock, so a rise is seen one cycle late;
    // the bit is taken as it stood before the rise, because the last bit floats with it
    always_ff @(posedge sys_clk_in)
    begin
        clk_prev_r  <= cfg_clk_in;
        data_prev_r <= cfg_data_in;
        if (clear_in)
            count_out <= 16'h0000;
        else if (cfg_clk_in && !clk_prev_r)
        begin
            bits_out[count_out] <= data_prev_r;
            count_out           <= count_out + 16'h0001;
        end
    end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the serial configuration readout
`timescale 1ns/10ps
module tb_top;
    import prom_pkg::*;
    localparam int unsigned AW = 8;
    localparam int unsigned NB = 1 << AW;
    logic          sys_clk_in;
    logic          reset_n_in;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic [31:0]   rd;
    logic          pready;
    logic          pslverr;
    logic          err;
    pin_in_t       pins;
    logic          data_o;
    logic          data_oe;
    logic          sclk_o;
    logic          sclk_oe;
    logic          casc_n;
    logic          rdy_oe;
    logic          stby;
    logic          prog;
    logic          sink_clr;
    logic [NB-1:0] got_bits;
    logic [15:0]   got_cnt;
    int            fails;
    int            n_checks;
    // released lines float up through the pin pull-ups
    wire           data_w = data_oe ? data_o : 1'b1;
    wire           sclk_w = sclk_oe ? sclk_o : 1'b1;

    serial_config_prom_readout #(.ADDR_W(AW)) u_dut (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .serial_prog_enable_in(pins.serial_prog_enable), .device_select_n_in(pins.sel_n),
        .reset_oe_in(pins.oe), .page_enable_in(pins.page_en),
        .partition_select_in(pins.part), .data_out(data_o), .data_oe_out(data_oe),
        .data_in(data_w), .serial_config_clock_out(sclk_o),
        .serial_config_clock_oe_out(sclk_oe), .serial_config_clock_in(sclk_w),
        .cascade_out_n_out(casc_n), .ready_out(), .ready_oe_out(rdy_oe),
        .standby_out(stby), .prog_mode_out(prog));

    fpga_cfg_sink #(.NBITS(NB)) u_sink (
        .sys_clk_in(sys_clk_in), .clear_in(sink_clr), .cfg_clk_in(sclk_w),
        .cfg_data_in(data_w), .bits_out(got_bits), .count_out(got_cnt));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // one apb transfer; read data and error are taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge sys_clk_in);
            if (pready === 1'b1)
                break;
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
        begin
            fails++;
            report_and_stop;
        end
    endtask

    task automatic wait_casc_low;
        int n;
        for (n = 0; n < 4000 && casc_n !== 1'b0; n++)
            @(posedge sys_clk_in);
        // one more edge so that the sink's last capture has landed
        @(posedge sys_clk_in);
        if (casc_n !== 1'b0)
        begin
            fails++;
            report_and_stop;
        end
    endtask

    function automatic logic [31:0] pat(input int w);
        return 32'(32'h9E37_79B9 * (w + 1));
    endfunction

    // stored words go out lsb first, word after word
    task automatic chk_stream(input int base, input int n);
        logic [31:0] w;
        chk32(32'(got_cnt), 32'(n), "bit count");
        for (int i = 0; i < n; i++)
        begin
            w = pat((base + i) >> 5);
            chk32({31'h0, got_bits[i]}, {31'h0, w[(base + i) % 32]}, "stream bit");
        end
    endtask

    initial
    begin
        fails = 0;
        n_checks = 0;
        reset_n_in = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pins = '{serial_prog_enable: 1'b1, sel_n: 1'b1, oe: 1'b1, page_en: 1'b0, part: 2'b00};
        sink_clr = 1'b1;
        repeat (4) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        @(posedge sys_clk_in);
        chk32({31'h0, rdy_oe}, 32'h1, "ready pulled low");
        for (int n = 0; n < 40 && rdy_oe !== 1'b0; n++)
            @(posedge sys_clk_in);
        chk32({31'h0, rdy_oe}, 32'h0, "ready released");
        apb(1'b0, CTRL_OFS, 32'h0);
        chk32({31'h0, rd[CTRL_HOLD_BIT]}, {31'h0, CTRL_HOLD_RST}, "ctrl reset");
        apb(1'b0, 8'h20, 32'h0);
        chk32({31'h0, err}, 32'h1, "unmapped error");
        chk32(rd, 32'h0, "unmapped data");
        apb(1'b1, MEM_ADDR_OFS, 32'h0);
        for (int w = 0; w < NB / 32; w++)
            apb(1'b1, MEM_DATA_OFS, pat(w));
        apb(1'b1, MEM_ADDR_OFS, 32'h3);
        apb(1'b0, MEM_DATA_OFS, 32'h0);
        chk32(rd, pat(3), "array word");
        chk32({30'h0, stby, data_oe}, 32'h2, "standby floats data");
        apb(1'b0, BIT_POS_OFS, 32'h0);
        chk32(rd, 32'h0, "no count when deselected");
        $display("test registers and standby done");
        sink_clr <= 1'b0;
        pins.sel_n <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        chk32({30'h0, data_oe, sclk_oe}, 32'h3, "selected drives data and clock");
        wait_casc_low;
        chk_stream(0, NB);
        chk32({30'h0, data_oe, sclk_oe}, 32'h0, "drivers off at end");
        pins.sel_n <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        chk32({31'h0, casc_n}, 32'h1, "cascade follows select high");
        pins.sel_n <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        chk32({31'h0, casc_n}, 32'h0, "cascade follows select low");
        $display("test full readout done");
        pins.oe <= 1'b0;
        pins.page_en <= 1'b1;
        pins.part <= 2'b10;
        sink_clr <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        chk32({30'h0, casc_n, data_oe}, 32'h2, "reset floats data");
        apb(1'b0, BIT_POS_OFS, 32'h0);
        chk32(rd, 32'h0, "counter cleared");
        apb(1'b1, CTRL_OFS, 32'h1);
        sink_clr <= 1'b0;
        pins.oe <= 1'b1;
        repeat (20) @(posedge sys_clk_in);
        chk32({30'h0, data_oe, sclk_oe}, 32'h2, "hold stops the clock");
        apb(1'b1, CTRL_OFS, 32'h0);
        wait_casc_low;
        chk_stream(NB / 2, NB / 4);
        $display("test paging done");
        pins.serial_prog_enable <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        chk32({31'h0, prog}, 32'h1, "programming mode");
        apb(1'b0, STATUS_OFS, 32'h0);
        chk32({31'h0, rd[ST_PROG_BIT]}, 32'h1, "status programming");
        $display("test programming mode done");
        report_and_stop;
    end
endmodule
